//--- hdl/reader_flags_consts.vh
`ifndef READER_FLAGS_CONSTS_VH
`define READER_FLAGS_CONSTS_VH
// Register addresses
`define ADDR_ERROR_FLAGS 6'h06
`define ADDR_STATUS_FLAGS_ONE 6'h07
// Error flag register bit positions
`define ERR_WRITE_VIOL 7
`define ERR_OVERHEAT 6
`define ERR_OVERFLOW 4
`define ERR_COLLISION 3
`define ERR_CHECKSUM 2
`define ERR_PARITY 1
`define ERR_FRAME_START 0
// Primary status register bit positions
`define ST_CRC_ZERO 6
`define ST_CRC_DONE 5
`define ST_IRQ_PENDING 4
`define ST_TIMER_ACTIVE 3
`define ST_NEAR_FULL 1
`define ST_NEAR_EMPTY 0
// Reset values
`define ERROR_FLAGS_RESET 8'h00
`define STATUS_FLAGS_RESET 8'h21
// Reserved masks, 1 where a bit exists
`define ERROR_FLAGS_MASK 8'hDF
`define STATUS_FLAGS_MASK 8'h7B
// FIFO geometry
`define FIFO_DEPTH 7'h40
`define FIFO_COUNT_ZERO 7'h00
`define FIFO_COUNT_ONE 7'h01
// Timer gate select code meaning not gated
`define TIMER_GATE_OFF 2'h0
`endif

//--- hdl/fifo_fill_tracker.v
`timescale 1ns/1ps
`include "reader_flags_consts.vh"
module fifo_fill_tracker #(
   parameter DEPTH = 64,
   parameter CW = 7
) (
   input wire sys_clk_i,
   input wire reset_n_i,
   input wire host_write_i,
   input wire host_read_i,
   input wire internal_write_i,
   input wire clear_i,
   input wire [5:0] fifo_threshold_i,
   output reg [CW-1:0] fifo_fill_count_o,
   output wire full_o,
   output wire fifo_near_full_o,
   output wire fifo_near_empty_o
);
   localparam [CW-1:0] DEPTH_W = DEPTH[CW-1:0];
   wire any_write;
   wire wr_ok;
   wire rd_ok;
   wire [CW-1:0] room;
   reg [CW-1:0] next_count;

   assign full_o = (fifo_fill_count_o == DEPTH_W);
   assign any_write = host_write_i | internal_write_i;
   assign wr_ok = any_write & ~full_o;
   assign rd_ok = host_read_i & (fifo_fill_count_o != `FIFO_COUNT_ZERO);
   assign room = DEPTH_W - fifo_fill_count_o;
   assign fifo_near_full_o = (room <= {1'b0, fifo_threshold_i});
   assign fifo_near_empty_o = (fifo_fill_count_o <= {1'b0, fifo_threshold_i});

   always @* begin
      next_count = fifo_fill_count_o;
      if (clear_i) begin
         next_count = `FIFO_COUNT_ZERO;
      end else if (wr_ok && !rd_ok) begin
         next_count = fifo_fill_count_o + `FIFO_COUNT_ONE;
      end else if (rd_ok && !wr_ok) begin
         next_count = fifo_fill_count_o - `FIFO_COUNT_ONE;
      end
   end

   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fifo_fill_count_o <= `FIFO_COUNT_ZERO;
      end else begin
         fifo_fill_count_o <= next_count;
      end
   end
endmodule // fifo_fill_tracker

//--- hdl/reader_error_status_flags.v
`timescale 1ns/1ps
`include "reader_flags_consts.vh"
module reader_error_status_flags #(
   parameter FIFO_DEPTH = 64,
   parameter COUNT_W = 7,
   parameter IRQ_W = 14
) (
   input wire sys_clk_i,
   input wire reset_n_i,
   // Register read port from the host interface logic
   input wire [5:0] reg_addr_i,
   input wire reg_read_i,
   output reg [7:0] reg_rdata_o,
   // FIFO access strobes
   input wire host_fifo_write_i,
   input wire host_fifo_read_i,
   input wire internal_fifo_write_i,
   input wire fifo_clear_strobe_i,
   input wire [5:0] fifo_threshold_i,
   output wire [COUNT_W-1:0] fifo_fill_count_o,
   // Command sequencer
   input wire command_start_i,
   input wire card_auth_command_i,
   input wire checksum_calc_command_i,
   // Transceiver window and receiver events
   input wire rf_tx_last_bit_i,
   input wire rf_rx_last_bit_i,
   input wire rx_startup_i,
   input wire lowest_rate_i,
   input wire rx_checksum_enable_i,
   input wire rx_collision_i,
   input wire rx_checksum_bad_i,
   input wire rx_parity_bad_i,
   input wire rx_frame_start_bad_i,
   input wire auth_byte_count_bad_i,
   // Temperature sensor pin, asynchronous
   input wire overheat_pin_i,
   output wire antenna_drivers_off_o,
   // Checksum coprocessor
   input wire crc_busy_i,
   input wire crc_finish_i,
   input wire crc_result_zero_i,
   // Interrupts and timer
   input wire [IRQ_W-1:0] irq_requests_i,
   input wire [IRQ_W-1:0] irq_enables_i,
   input wire timer_started_i,
   input wire timer_stopped_i,
   input wire [1:0] timer_gate_select_i,
   output wire error_irq_request_o,
   output wire [7:0] error_flag_register_o,
   output wire [7:0] primary_status_register_o
);
   reg heat_meta;
   reg heat_sync;
   reg in_tx_rx_gap;
   reg fifo_write_violation;
   reg overheat_flag;
   reg fifo_overflow_flag;
   reg bit_collision_flag;
   reg checksum_fail_flag;
   reg parity_fail_flag;
   reg frame_start_fault_flag;
   reg checksum_zero_flag;
   reg checksum_done_flag;
   reg timer_run;
   wire fifo_full;
   wire fifo_near_full;
   wire fifo_near_empty;
   wire timer_active_flag;
   wire any_fifo_write;

   // Next values of the flag and window registers
   reg next_write_violation;
   reg next_overflow;
   reg next_collision;
   reg next_checksum_fail;
   reg next_parity_fail;
   reg next_frame_fault;
   reg next_gap;
   reg next_timer_run;
   reg [7:0] error_bits;
   reg [7:0] status_bits;
   wire write_in_window;
   wire frame_fault_event;
   wire rx_restart;
   wire irq_pending;

   // Set beats clear in every flag below
   function next_flag;
      input cur;
      input clr;
      input set;
      begin
         next_flag = set | (cur & ~clr);
      end
   endfunction

   fifo_fill_tracker #(
      .DEPTH(FIFO_DEPTH),
      .CW(COUNT_W)
   ) u_fill (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .host_write_i(host_fifo_write_i),
      .host_read_i(host_fifo_read_i),
      .internal_write_i(internal_fifo_write_i),
      .clear_i(fifo_clear_strobe_i),
      .fifo_threshold_i(fifo_threshold_i),
      .fifo_fill_count_o(fifo_fill_count_o),
      .full_o(fifo_full),
      .fifo_near_full_o(fifo_near_full),
      .fifo_near_empty_o(fifo_near_empty)
   );

   assign any_fifo_write = host_fifo_write_i | internal_fifo_write_i;

   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         heat_meta <= 1'b0;
         heat_sync <= 1'b0;
      end else begin
         heat_meta <= overheat_pin_i;
         heat_sync <= heat_meta;
      end
   end

   // Window from last transmitted bit to last received bit
   always @* begin
      next_gap = in_tx_rx_gap;
      if (rf_rx_last_bit_i || command_start_i) begin
         next_gap = 1'b0;
      end else if (rf_tx_last_bit_i) begin
         next_gap = 1'b1;
      end
   end

   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         in_tx_rx_gap <= 1'b0;
      end else begin
         in_tx_rx_gap <= next_gap;
      end
   end

   // Receiver start-up and command start both wipe the receive error group
   assign rx_restart = command_start_i | rx_startup_i;
   assign write_in_window = card_auth_command_i | in_tx_rx_gap;
   assign frame_fault_event = (lowest_rate_i & rx_frame_start_bad_i)
      | (card_auth_command_i & auth_byte_count_bad_i);

   always @* begin
      next_write_violation = next_flag(fifo_write_violation, command_start_i,
         host_fifo_write_i & write_in_window);
      next_overflow = next_flag(fifo_overflow_flag,
         command_start_i | fifo_clear_strobe_i, any_fifo_write & fifo_full);
      // Forced low above the lowest rate, even when an event arrives
      next_collision = lowest_rate_i
         & next_flag(bit_collision_flag, rx_restart, rx_collision_i);
      next_checksum_fail = next_flag(checksum_fail_flag, rx_restart,
         rx_checksum_enable_i & rx_checksum_bad_i);
      next_parity_fail = next_flag(parity_fail_flag, rx_restart,
         lowest_rate_i & rx_parity_bad_i);
      next_frame_fault = next_flag(frame_start_fault_flag, rx_restart,
         frame_fault_event);
   end

   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         fifo_write_violation <= 1'b0;
         overheat_flag <= 1'b0;
         fifo_overflow_flag <= 1'b0;
         bit_collision_flag <= 1'b0;
         checksum_fail_flag <= 1'b0;
         parity_fail_flag <= 1'b0;
         frame_start_fault_flag <= 1'b0;
      end else begin
         fifo_write_violation <= next_write_violation;
         // Overheat is cleared only when the sensor reports cool again
         overheat_flag <= heat_sync;
         fifo_overflow_flag <= next_overflow;
         bit_collision_flag <= next_collision;
         checksum_fail_flag <= next_checksum_fail;
         parity_fail_flag <= next_parity_fail;
         frame_start_fault_flag <= next_frame_fault;
      end
   end

   assign antenna_drivers_off_o = overheat_flag;

   // Checksum coprocessor progress; a finish in a busy cycle wins
   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         checksum_zero_flag <= 1'b0;
      end else if (crc_finish_i) begin
         checksum_zero_flag <= crc_result_zero_i;
      end else if (crc_busy_i) begin
         checksum_zero_flag <= 1'b0;
      end
   end

   // Done resets high and is set only by a finish of the standalone calculation command; a busy cycle of any command clears it
   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         checksum_done_flag <= 1'b1;
      end else if (crc_finish_i && checksum_calc_command_i) begin
         checksum_done_flag <= 1'b1;
      end else if (crc_busy_i) begin
         checksum_done_flag <= 1'b0;
      end
   end

   // Run state follows start/stop, never the external gate level
   // Gate select stays out of this on purpose, whatever mode is chosen
   always @* begin
      next_timer_run = timer_run;
      if (timer_started_i) begin
         next_timer_run = 1'b1;
      end else if (timer_stopped_i) begin
         next_timer_run = 1'b0;
      end
   end

   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         timer_run <= 1'b0;
      end else begin
         timer_run <= next_timer_run;
      end
   end

   assign timer_active_flag = timer_run;

   // Reserved positions stay zero; no write path reaches them
   always @* begin
      error_bits = `ERROR_FLAGS_RESET;
      error_bits[`ERR_WRITE_VIOL] = fifo_write_violation;
      error_bits[`ERR_OVERHEAT] = overheat_flag;
      error_bits[`ERR_OVERFLOW] = fifo_overflow_flag;
      error_bits[`ERR_COLLISION] = bit_collision_flag;
      error_bits[`ERR_CHECKSUM] = checksum_fail_flag;
      error_bits[`ERR_PARITY] = parity_fail_flag;
      error_bits[`ERR_FRAME_START] = frame_start_fault_flag;
   end

   assign error_flag_register_o = error_bits & `ERROR_FLAGS_MASK;
   assign error_irq_request_o = |error_flag_register_o;
   // Left combinational so enable changes show without a cycle of lag
   assign irq_pending = |(irq_requests_i & irq_enables_i);

   always @* begin
      status_bits = 8'h00;
      status_bits[`ST_CRC_ZERO] = checksum_zero_flag;
      status_bits[`ST_CRC_DONE] = checksum_done_flag;
      status_bits[`ST_IRQ_PENDING] = irq_pending;
      status_bits[`ST_TIMER_ACTIVE] = timer_active_flag;
      status_bits[`ST_NEAR_FULL] = fifo_near_full;
      status_bits[`ST_NEAR_EMPTY] = fifo_near_empty;
   end

   assign primary_status_register_o = status_bits & `STATUS_FLAGS_MASK;

   // Read data held in a register; unmapped addresses read zero
   always @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= `ERROR_FLAGS_RESET;
      end else if (reg_read_i) begin
         case (reg_addr_i)
            `ADDR_ERROR_FLAGS: begin
               reg_rdata_o <= error_flag_register_o;
            end
            `ADDR_STATUS_FLAGS_ONE: begin
               reg_rdata_o <= primary_status_register_o;
            end
            default: begin
               reg_rdata_o <= 8'h00;
            end
         endcase
      end
   end
endmodule // reader_error_status_flags

//--- verif/flags_monitor.sv
`timescale 1ns/1ps
module flags_monitor #(
   parameter COUNT_W = 7,
   parameter IRQ_W = 14
) (
   input wire sys_clk_i,
   input wire reset_n_i,
   input wire host_fifo_write_i,
   input wire internal_fifo_write_i,
   input wire command_start_i,
   input wire lowest_rate_i,
   input wire rx_checksum_enable_i,
   input wire rx_checksum_bad_i,
   input wire overheat_pin_i,
   input wire antenna_drivers_off_o,
   input wire [5:0] fifo_threshold_i,
   input wire [COUNT_W-1:0] fifo_fill_count_o,
   input wire [IRQ_W-1:0] irq_requests_i,
   input wire [IRQ_W-1:0] irq_enables_i,
   input wire error_irq_request_o,
   input wire [7:0] error_flag_register_o,
   input wire [7:0] primary_status_register_o
);
   wire [7:0] e = error_flag_register_o;
   wire [7:0] s = primary_status_register_o;
   wire [COUNT_W-1:0] thr = COUNT_W'(fifo_threshold_i);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   a_ovfl_set: assert property ((host_fifo_write_i || internal_fifo_write_i)
      && fifo_fill_count_o == 64 |=> e[4]) else $error("overflow flag missed");
   a_cmd_clear: assert property (command_start_i && !host_fifo_write_i
      && !internal_fifo_write_i |=> !e[7] && !e[4]) else $error("command start kept errors");
   a_rsvd_zero: assert property (!e[5] && !s[7] && !s[2])
      else $error("reserved bit set");
   a_irq_sum: assert property (s[4] == |(irq_requests_i & irq_enables_i))
      else $error("pending summary wrong");
   a_err_irq: assert property (error_irq_request_o == |e)
      else $error("error request wrong");
   a_lo_alert: assert property (s[0] == (fifo_fill_count_o <= thr))
      else $error("near empty wrong");
   a_hi_alert: assert property (s[1] == (64 - fifo_fill_count_o <= thr))
      else $error("near full wrong");
   a_coll_fast: assert property (!lowest_rate_i ##1 !lowest_rate_i |-> !e[3])
      else $error("collision at high rate");
   a_crc_gate: assert property (!e[2] && !(rx_checksum_bad_i && rx_checksum_enable_i)
      |=> !e[2]) else $error("checksum flag unexpected");
   a_heat_off: assert property ($rose(overheat_pin_i) |-> ##[1:4]
      (e[6] && antenna_drivers_off_o)) else $error("overheat not flagged");
endmodule // flags_monitor
bind reader_error_status_flags flags_monitor #(.COUNT_W(COUNT_W), .IRQ_W(IRQ_W)) u_mon (
   .sys_clk_i(sys_clk_i),
   .reset_n_i(reset_n_i),
   .host_fifo_write_i(host_fifo_write_i),
   .internal_fifo_write_i(internal_fifo_write_i),
   .command_start_i(command_start_i),
   .lowest_rate_i(lowest_rate_i),
   .rx_checksum_enable_i(rx_checksum_enable_i),
   .rx_checksum_bad_i(rx_checksum_bad_i),
   .overheat_pin_i(overheat_pin_i),
   .antenna_drivers_off_o(antenna_drivers_off_o),
   .fifo_threshold_i(fifo_threshold_i),
   .fifo_fill_count_o(fifo_fill_count_o),
   .irq_requests_i(irq_requests_i),
   .irq_enables_i(irq_enables_i),
   .error_irq_request_o(error_irq_request_o),
   .error_flag_register_o(error_flag_register_o),
   .primary_status_register_o(primary_status_register_o)
);

//--- verif/host_reg_model.sv
`timescale 1ns/1ps
module host_reg_model (
   input wire sys_clk_i,
   input wire [7:0] reg_rdata_i,
   output logic [5:0] reg_addr_o = 6'h00,
   output logic reg_read_o = 1'b0
);
   task rd(input logic [5:0] a, output logic [7:0] d);
      @(negedge sys_clk_i);
      reg_addr_o = a;
      reg_read_o = 1'b1;
      @(negedge sys_clk_i);
      reg_read_o = 1'b0;
      // Stale address would hide a decoder that ignores the strobe
      reg_addr_o = ~a;
      @(negedge sys_clk_i);
      d = reg_rdata_i;
   endtask
endmodule // host_reg_model

//--- verif/test_reader_error_status_flags.sv
`timescale 1ns/1ps
`include "reader_flags_consts.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
`define P(s) begin s = 1; @(negedge sys_clk_i); s = 0; end
module test_reader_error_status_flags;
   logic sys_clk_i = 0, reset_n_i = 0, host_fifo_write_i = 0, host_fifo_read_i = 0;
   logic internal_fifo_write_i = 0, fifo_clear_strobe_i = 0, command_start_i = 0;
   logic card_auth_command_i = 0, checksum_calc_command_i = 0, rf_tx_last_bit_i = 0;
   logic rf_rx_last_bit_i = 0, rx_startup_i = 0, lowest_rate_i = 1, rx_checksum_enable_i = 1;
   logic rx_collision_i = 0, rx_checksum_bad_i = 0, rx_parity_bad_i = 0;
   logic rx_frame_start_bad_i = 0, auth_byte_count_bad_i = 0, overheat_pin_i = 0;
   logic crc_busy_i = 0, crc_finish_i = 0, crc_result_zero_i = 0;
   logic timer_started_i = 0, timer_stopped_i = 0;
   logic [1:0] timer_gate_select_i = 2'h0;
   logic [5:0] fifo_threshold_i = 6'h04;
   logic [13:0] irq_requests_i = 14'h0000, irq_enables_i = 14'h0000;
   wire [5:0] reg_addr_i;
   wire reg_read_i, antenna_drivers_off_o, error_irq_request_o;
   wire [6:0] fifo_fill_count_o;
   wire [7:0] reg_rdata_o, error_flag_register_o, primary_status_register_o;
   int err_count = 0, tests_run = 0, i;
   reader_error_status_flags DUT (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i),
      .reg_read_i(reg_read_i),
      .reg_rdata_o(reg_rdata_o),
      .host_fifo_write_i(host_fifo_write_i),
      .host_fifo_read_i(host_fifo_read_i),
      .internal_fifo_write_i(internal_fifo_write_i),
      .fifo_clear_strobe_i(fifo_clear_strobe_i),
      .fifo_threshold_i(fifo_threshold_i),
      .fifo_fill_count_o(fifo_fill_count_o),
      .command_start_i(command_start_i),
      .card_auth_command_i(card_auth_command_i),
      .checksum_calc_command_i(checksum_calc_command_i),
      .rf_tx_last_bit_i(rf_tx_last_bit_i),
      .rf_rx_last_bit_i(rf_rx_last_bit_i),
      .rx_startup_i(rx_startup_i),
      .lowest_rate_i(lowest_rate_i),
      .rx_checksum_enable_i(rx_checksum_enable_i),
      .rx_collision_i(rx_collision_i),
      .rx_checksum_bad_i(rx_checksum_bad_i),
      .rx_parity_bad_i(rx_parity_bad_i),
      .rx_frame_start_bad_i(rx_frame_start_bad_i),
      .auth_byte_count_bad_i(auth_byte_count_bad_i),
      .overheat_pin_i(overheat_pin_i),
      .antenna_drivers_off_o(antenna_drivers_off_o),
      .crc_busy_i(crc_busy_i),
      .crc_finish_i(crc_finish_i),
      .crc_result_zero_i(crc_result_zero_i),
      .irq_requests_i(irq_requests_i),
      .irq_enables_i(irq_enables_i),
      .timer_started_i(timer_started_i),
      .timer_stopped_i(timer_stopped_i),
      .timer_gate_select_i(timer_gate_select_i),
      .error_irq_request_o(error_irq_request_o),
      .error_flag_register_o(error_flag_register_o),
      .primary_status_register_o(primary_status_register_o)
   );
   host_reg_model host (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o),
      .reg_addr_o(reg_addr_i), .reg_read_o(reg_read_i));
   always #20 sys_clk_i = ~sys_clk_i;
   task conclude;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task ck(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      `CHK(d, e)
   endtask
   initial begin
      repeat (4) @(negedge sys_clk_i);
      reset_n_i = 1;
      ck(`ADDR_ERROR_FLAGS, 8'h00);
      ck(`ADDR_STATUS_FLAGS_ONE, 8'h21);
      ck(6'h3F, 8'h00);
      $display("reset test done");
      for (i = 1; i <= 64; i++) begin
         `P(host_fifo_write_i)
         `CHK(fifo_fill_count_o, 7'(i))
         `CHK(primary_status_register_o[1:0], {1'(i >= 60), 1'(i <= 4)})
         @(negedge sys_clk_i);
      end
      `P(internal_fifo_write_i)
      `CHK({error_irq_request_o, error_flag_register_o}, 9'h110)
      `P(host_fifo_read_i)
      `CHK(fifo_fill_count_o, 7'h3F)
      `P(fifo_clear_strobe_i)
      `CHK({fifo_fill_count_o, error_flag_register_o}, 15'h0000)
      $display("fifo test done");
      card_auth_command_i = 1;
      `P(host_fifo_write_i)
      `P(auth_byte_count_bad_i)
      `CHK(error_flag_register_o, 8'h81)
      card_auth_command_i = 0;
      `P(command_start_i)
      ck(`ADDR_ERROR_FLAGS, 8'h00);
      `P(rf_tx_last_bit_i)
      `P(host_fifo_write_i)
      `CHK(error_flag_register_o, 8'h80)
      `P(rf_rx_last_bit_i)
      `P(command_start_i)
      `P(host_fifo_write_i)
      `CHK(error_flag_register_o, 8'h00)
      `P(rx_collision_i)
      `P(rx_checksum_bad_i)
      `P(rx_parity_bad_i)
      `P(rx_frame_start_bad_i)
      `CHK(error_flag_register_o, 8'h0F)
      `P(rx_startup_i)
      `CHK(error_flag_register_o, 8'h00)
      rx_checksum_enable_i = 0;
      lowest_rate_i = 0;
      `P(rx_checksum_bad_i)
      `P(rx_collision_i)
      `P(rx_parity_bad_i)
      `P(rx_frame_start_bad_i)
      `CHK(error_flag_register_o, 8'h00)
      overheat_pin_i = 1;
      repeat (5) @(negedge sys_clk_i);
      `CHK({antenna_drivers_off_o, error_flag_register_o}, 9'h140)
      `P(command_start_i)
      `CHK(error_flag_register_o, 8'h40)
      overheat_pin_i = 0;
      repeat (5) @(negedge sys_clk_i);
      $display("error test done");
      checksum_calc_command_i = 1;
      crc_busy_i = 1;
      @(negedge sys_clk_i);
      `CHK(primary_status_register_o[6:5], 2'h0)
      crc_busy_i = 0;
      crc_result_zero_i = 1;
      `P(crc_finish_i)
      `CHK(primary_status_register_o[6:5], 2'h3)
      `P(timer_started_i)
      timer_gate_select_i = 2'h2;
      @(negedge sys_clk_i);
      `CHK(primary_status_register_o[3], 1'b1)
      `P(timer_stopped_i)
      `CHK(primary_status_register_o[3], 1'b0)
      irq_requests_i = 14'h0008;
      @(negedge sys_clk_i);
      `CHK(primary_status_register_o[4], 1'b0)
      irq_enables_i = 14'h0008;
      @(negedge sys_clk_i);
      ck(`ADDR_STATUS_FLAGS_ONE, 8'h71);
      $display("status test done");
      conclude;
   end
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      err_count++;
      conclude;
   end
endmodule // test_reader_error_status_flags
